// [core/aha_attention.sv]
// Purpose: Attention request and overflow flag of the postprocessor host port
// Assumes: Master clock runs continuously; strobes synchronous to sys_clk
// Notes:   Port mode is latched once after reset release
//
// What this block does
// - In serial mode the overflow flag output is low without overflow and high on overflow.
// - In parallel mode the attention output rests low and rises only for a defined cause.
// - Instruction completion raises attention; an instruction write or status read clears it.
// - A write-data request raises attention; a host data write clears it.
// - Read data becoming ready raises attention; a host data read clears it.
// - A configuration ID/checksum error or overflow raises attention; only a status read clears it.
// - Completing power-on reset raises attention until the host reads status.
// - Read/write select high starts a read, low starts a write.
// - Bus cycles count only while chip select is low.
// - Interface select low picks parallel, high picks serial, sampled at power-up.
// - Register selector high addresses status/instruction, low addresses data transfers.
`timescale 1ns/1ps

module aha_attention
    import aha_pkg::*;
#(
    parameter logic [3:0] POR_DELAY = POR_CYCLES
)
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    // Interface select strap
    input  wire logic interface_select,
    // Parallel bus
    input  wire logic cycle_strobe,
    input  wire logic chip_select_n,
    input  wire logic read_write_sel,
    input  wire logic register_selector,
    // Postprocessor events
    input  wire logic instr_done,
    input  wire logic write_data_req,
    input  wire logic read_data_ready,
    input  wire logic cfg_error,
    input  wire logic pp_overflow,
    // Outputs
    output logic      attention_out,
    output logic      overflow_flag_out,
    output logic      serial_mode,
    output logic      por_done,
    output logic      status_read,
    output logic      instr_write,
    output logic      data_read,
    output logic      data_write,
    output logic [4:0] cause_pending
);
    import aha_pkg::*;

    aha_acc_e   acc;
    logic       mode_taken_reg,  mode_taken_next;
    logic       serial_reg,      serial_next;
    logic [3:0] por_cnt_reg,     por_cnt_next;
    logic       por_done_reg,    por_done_next;
    logic [4:0] cause_reg,       cause_next;
    logic       attn_reg,        attn_next;
    logic       ovf_reg,         ovf_next;
    logic       st_rd_reg, st_rd_next, in_wr_reg, in_wr_next;
    logic       d_rd_reg, d_rd_next, d_wr_reg, d_wr_next;
    logic       st_rd_c, in_wr_c, d_rd_c, d_wr_c;
    logic       ev_done, ev_wreq, ev_rdy, ev_err, ev_por;

    // Cycle qualification
    aha_access_decode u_decode (
        .cycle_strobe   (cycle_strobe),
        .chip_select_n  (chip_select_n),
        .read_write_sel (read_write_sel),
        .acc            (acc)
    );

    // Next sticky value: set wins over clear
    function automatic logic sticky(input logic cur, input logic set, input logic clr);
        sticky = set | (cur & ~clr);
    endfunction

    // Access decode, parallel mode only; selector splits control from data
    always_comb
    begin
        st_rd_c = 1'b0;
        in_wr_c = 1'b0;
        d_rd_c  = 1'b0;
        d_wr_c  = 1'b0;
        if (mode_taken_reg && !serial_reg)
        begin
            st_rd_c = acc == AHA_ACC_READ  && register_selector == SEL_CTRL;
            in_wr_c = acc == AHA_ACC_WRITE && register_selector == SEL_CTRL;
            d_rd_c  = acc == AHA_ACC_READ  && register_selector == SEL_DATA;
            d_wr_c  = acc == AHA_ACC_WRITE && register_selector == SEL_DATA;
        end
    end

    // Port mode strap, caught once after reset release and then frozen
    always_comb
    begin
        mode_taken_next = 1'b1;
        serial_next     = mode_taken_reg ? serial_reg
                        : (interface_select == PORT_SERIAL);
    end

    // Power-on reset completion counter
    always_comb
    begin
        por_cnt_next  = por_cnt_reg;
        por_done_next = por_done_reg;
        ev_por        = 1'b0;
        if (!por_done_reg)
        begin
            if (por_cnt_reg >= POR_DELAY - 4'h1)
            begin
                por_done_next = 1'b1;
                ev_por        = 1'b1;
            end
            else
            begin
                por_cnt_next = por_cnt_reg + 4'h1;
            end
        end
    end

    // Cause events and per-cause clears
    always_comb
    begin
        ev_done = instr_done;
        ev_wreq = write_data_req;
        ev_rdy  = read_data_ready;
        ev_err  = cfg_error | pp_overflow;
        cause_next[C_DONE] = sticky(cause_reg[C_DONE], ev_done, in_wr_c | st_rd_c);
        cause_next[C_WREQ] = sticky(cause_reg[C_WREQ], ev_wreq, d_wr_c);
        cause_next[C_RDY]  = sticky(cause_reg[C_RDY],  ev_rdy,  d_rd_c);
        cause_next[C_ERR]  = sticky(cause_reg[C_ERR],  ev_err,  st_rd_c);
        cause_next[C_POR]  = sticky(cause_reg[C_POR],  ev_por,  st_rd_c);
        // Attention only in parallel mode, OR of all pending
        attn_next = !serial_next && (|cause_next);
        // Overflow flag follows overflow in serial mode
        ovf_next  = serial_next && pp_overflow;
        st_rd_next = st_rd_c;
        in_wr_next = in_wr_c;
        d_rd_next  = d_rd_c;
        d_wr_next  = d_wr_c;
    end

    // State registers, frozen while clock enable is low
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_taken_reg <= 1'b0;
            serial_reg     <= SERIAL_RESET;
            por_cnt_reg    <= 4'h0;
            por_done_reg   <= 1'b0;
            cause_reg      <= CAUSE_RESET;
            attn_reg       <= ATTN_RESET;
            ovf_reg        <= 1'b0;
            st_rd_reg      <= 1'b0;
            in_wr_reg      <= 1'b0;
            d_rd_reg       <= 1'b0;
            d_wr_reg       <= 1'b0;
        end
        else if (clk_en)
        begin
            mode_taken_reg <= mode_taken_next;
            serial_reg     <= serial_next;
            por_cnt_reg    <= por_cnt_next;
            por_done_reg   <= por_done_next;
            cause_reg      <= cause_next;
            attn_reg       <= attn_next;
            ovf_reg        <= ovf_next;
            st_rd_reg      <= st_rd_next;
            in_wr_reg      <= in_wr_next;
            d_rd_reg       <= d_rd_next;
            d_wr_reg       <= d_wr_next;
        end
    end

    // Outputs straight from flip-flops
    assign attention_out     = attn_reg;
    assign overflow_flag_out = ovf_reg;
    assign serial_mode       = serial_reg;
    assign por_done          = por_done_reg;
    assign status_read       = st_rd_reg;
    assign instr_write       = in_wr_reg;
    assign data_read         = d_rd_reg;
    assign data_write        = d_wr_reg;
    assign cause_pending     = cause_reg;
endmodule

// [include/aha_pkg.sv]
// Purpose: Shared constants for the host attention and port select block
// Assumes: One system clock; bus strobes synchronous to it
// Notes:   Bus field encodings and reset values live here

package aha_pkg;
    // Bus field encodings
    localparam logic       RW_READ        = 1'b1;
    localparam logic       RW_WRITE       = 1'b0;
    localparam logic       SEL_CTRL       = 1'b1;
    localparam logic       SEL_DATA       = 1'b0;
    localparam logic       PORT_PARALLEL  = 1'b0;
    localparam logic       PORT_SERIAL    = 1'b1;
    localparam logic       CS_ACTIVE      = 1'b0;
    // Reset values
    localparam logic       ATTN_RESET     = 1'b0;
    localparam logic       SERIAL_RESET   = 1'b0;
    // Cause vector layout
    localparam int         CAUSE_W        = 5;
    localparam int         C_DONE         = 0;
    localparam int         C_WREQ         = 1;
    localparam int         C_RDY          = 2;
    localparam int         C_ERR          = 3;
    localparam int         C_POR          = 4;
    localparam logic [4:0] CAUSE_RESET    = 5'h00;
    // Power-on reset completion delay in system clocks
    localparam logic [3:0] POR_CYCLES     = 4'h8;

    // Access classes decoded from a qualified bus cycle
    typedef enum logic [1:0] {
        AHA_ACC_NONE,
        AHA_ACC_READ,
        AHA_ACC_WRITE
    } aha_acc_e;
endpackage

// [core/aha_access_decode.sv]
// Purpose: Qualify one parallel bus cycle into an access class
// Assumes: Strobe is a one-cycle pulse marking a bus cycle
// Notes:   Purely combinational; registered by the caller
`timescale 1ns/1ps

module aha_access_decode
    import aha_pkg::*;
(
    // Bus pins
    input  wire logic      cycle_strobe,
    input  wire logic      chip_select_n,
    input  wire logic      read_write_sel,
    // Result
    output aha_pkg::aha_acc_e acc
);
    // Only cycles with chip select low count; direction from select pin
    always_comb
    begin
        acc = AHA_ACC_NONE;
        if (cycle_strobe && chip_select_n == CS_ACTIVE)
        begin
            acc = (read_write_sel == RW_READ) ? AHA_ACC_READ : AHA_ACC_WRITE;
        end
    end
endmodule

// [dv/aha_attention_sva.sv]
// Purpose: Port checks for the attention block
// Assumes: Checks pause on any edge with clk_en low
// Notes:   Bound to every aha_attention
`timescale 1ns/1ps

module aha_attention_sva
    import aha_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       clk_en,
    // Bus and events
    input wire logic       cycle_strobe,
    input wire logic       chip_select_n,
    input wire logic       read_write_sel,
    input wire logic       register_selector,
    input wire logic       instr_done,
    input wire logic       pp_overflow,
    // Outputs watched
    input wire logic       attention_out,
    input wire logic       overflow_flag_out,
    input wire logic       serial_mode,
    input wire logic       status_read,
    input wire logic       instr_write,
    input wire logic       data_read,
    input wire logic       data_write,
    input wire logic [4:0] cause_pending
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n || !clk_en);
    // Qualified data read cycle
    sequence s_rd_data;
        !serial_mode && cycle_strobe && !chip_select_n && read_write_sel && !register_selector;
    endsequence
    property p_ovf;
        serial_mode && $past(serial_mode) |-> overflow_flag_out == $past(pp_overflow);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag lag wrong");
    property p_or;
        !serial_mode |-> attention_out == (|cause_pending);
    endproperty
    a_or: assert property (p_or) else $error("attention not OR of causes");
    property p_done;
        !serial_mode && instr_done |=> cause_pending[C_DONE];
    endproperty
    a_done: assert property (p_done) else $error("done cause not set");
    property p_err;
        !serial_mode && pp_overflow |=> cause_pending[C_ERR];
    endproperty
    a_err: assert property (p_err) else $error("error cause not set");
    property p_dclr;
        $fell(cause_pending[C_DONE]) |-> status_read || instr_write;
    endproperty
    a_dclr: assert property (p_dclr) else $error("done cleared wrongly");
    property p_eclr;
        $fell(cause_pending[C_ERR]) || $fell(cause_pending[C_POR]) |-> status_read;
    endproperty
    a_eclr: assert property (p_eclr) else $error("error cleared wrongly");
    property p_dec;
        s_rd_data |=> data_read;
    endproperty
    a_dec: assert property (p_dec) else $error("data read not decoded");
    property p_cs;
        cycle_strobe && chip_select_n |=> !(status_read || instr_write || data_read || data_write);
    endproperty
    a_cs: assert property (p_cs) else $error("unselected cycle taken");
endmodule

bind aha_attention aha_attention_sva u_sva (.*);

// [dv/aha_host_model.sv]
// Purpose: Host processor side of the parallel bus
// Assumes: Tasks called at falling edges
// Notes:   Released read/write and register select lines show inverted values; read/write stays low in serial
`timescale 1ns/1ps

module aha_host_model
(
    // Bus outputs
    output logic cycle_strobe,
    output logic chip_select_n,
    output logic read_write_sel,
    output logic register_selector
);
    logic ser_q;
    // Bus idle at start
    initial
    begin
        cycle_strobe = 1'b0;
        chip_select_n = 1'b1;
        read_write_sel = 1'b0;
        register_selector = 1'b0;
        ser_q = 1'b0;
    end
    // Start one bus cycle
    task automatic start(input logic cs_n, input logic rw, input logic sel, input logic ser);
        ser_q = ser;
        cycle_strobe = 1'b1;
        chip_select_n = cs_n;
        read_write_sel = rw & ~ser;
        register_selector = sel;
    endtask
    // Release the bus
    task automatic stop();
        cycle_strobe = 1'b0;
        chip_select_n = 1'b1;
        read_write_sel = ~read_write_sel & ~ser_q;
        register_selector = ~register_selector;
    endtask
endmodule

// [dv/test_adc_host_attention_and_port_select.sv]
// Purpose: Self-checking bench for the attention block
// Assumes: Host model drives the bus at falling edges
// Notes:   Power-on count shortened to two clocks
`timescale 1ns/1ps

module test_adc_host_attention_and_port_select;
    import aha_pkg::*;
    logic       sys_clk, rst_n, sel_in, ovf, attn, ovf_flag, ser, por, sr, iw, dr, dw;
    logic       stb, cs_n, rw, rsel, en;
    // External clock source drives the master clock pin, so oscillator off
    logic       oscillator_disable;
    assign oscillator_disable = 1'b1;
    logic [4:0] ev, cause, exp_c;
    int         n_mismatch, total_checks, seed;
    localparam logic [4:0] CLR [4] = '{5'h02, 5'h04, 5'h01, 5'h19};
    aha_attention #(.POR_DELAY(4'h2)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(en),
        .interface_select(sel_in), .cycle_strobe(stb), .chip_select_n(cs_n),
        .read_write_sel(rw), .register_selector(rsel), .instr_done(ev[0]),
        .write_data_req(ev[1]), .read_data_ready(ev[2]), .cfg_error(ev[3]),
        .pp_overflow(ovf), .attention_out(attn), .overflow_flag_out(ovf_flag),
        .serial_mode(ser), .por_done(por), .status_read(sr), .instr_write(iw),
        .data_read(dr), .data_write(dw), .cause_pending(cause));
    aha_host_model host (.cycle_strobe(stb), .chip_select_n(cs_n), .read_write_sel(rw),
        .register_selector(rsel));
    // Clock, free running without gaps for the whole run
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Compare and count
    task automatic check(string what, logic [4:0] seen, logic [4:0] want);
        total_checks++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One random event or host access, then compare with the model
    task automatic step();
        int k;
        logic [2:0] b;
        k = $unsigned($random(seed)) % 7;
        b = 3'($random(seed));
        @(negedge sys_clk);
        if (k < 4) ev[k] = 1'b1;
        else if (k == 4) ovf = 1'b1;
        else host.start(b[2], b[1], b[0], 1'b0);
        @(negedge sys_clk);
        ev = '0;
        ovf = 1'b0;
        if (k < 5) exp_c[k < 4 ? k : 3] = 1'b1;
        else if (!b[2]) exp_c = exp_c & ~CLR[{b[0], b[1]}];
        check("pulses", {1'b0, sr, iw, dr, dw}, (k > 4 && !b[2]) ? 5'h1 << {b[0], b[1]} : 5'h0);
        if (k > 4) host.stop();
        check("cause", cause, exp_c);
        check("attn", {4'h0, attn}, {4'h0, |exp_c});
    endtask
    // Main sequence
    initial
    begin
        seed = 32'h01d1;
        {ev, ovf, sel_in, rst_n, exp_c} = '0;
        en = 1'b1;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk) rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        exp_c = 5'h10;
        check("por", cause, exp_c);
        check("por_done", {4'h0, por}, 5'h01);
        check("mode", {4'h0, ser}, {4'h0, PORT_PARALLEL});
        $display("power-on test done");
        repeat (80) step();
        $display("random access test done");
        // Clock enable low freezes all state, events included
        @(negedge sys_clk);
        en = 1'b0;
        ev[0] = 1'b1;
        @(negedge sys_clk);
        check("freeze", cause, exp_c);
        ev = '0;
        en = 1'b1;
        $display("freeze test done");
        // Mode change only through a full reset, standing in for power cycle
        rst_n = 1'b0;
        sel_in = PORT_SERIAL;
        @(negedge sys_clk) rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("mode", {4'h0, ser}, {4'h0, PORT_SERIAL});
        repeat (30)
        begin
            @(negedge sys_clk);
            check("ovf", {4'h0, ovf_flag}, {4'h0, ovf});
            check("quiet", {attn, sr, iw, dr, dw}, 5'h0);
            ovf = 1'($random(seed));
            host.start(1'b0, 1'b1, 1'b1, 1'b1);
        end
        $display("serial test done");
        tally_and_finish();
    end
    // Watchdog
    initial
    begin
        #125000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
